// ---- lutr_map.vh ----
/*
  Register map, field positions, mode codes and reset values of the
  lookup-table RAM block. Assumes inclusion by bare name from design files.
*/
`ifndef LUTR_MAP_VH
`define LUTR_MAP_VH

// ==========================================================================
// register byte offsets (apb, one aligned word each)
`define LUTR_OFS_CTRL 8'h00
`define LUTR_OFS_STATUS 8'h04
`define LUTR_OFS_CONT_LO 8'h08
`define LUTR_OFS_CONT_HI 8'h0C

// ==========================================================================
// control fields
`define LUTR_CTRL_MODE_LSB 0
`define LUTR_CTRL_MODE_MSB 1
`define LUTR_CTRL_FALL_BIT 2
`define LUTR_CTRL_RELOAD_BIT 8

// ==========================================================================
// status fields
`define LUTR_STAT_CNT_LSB 0
`define LUTR_STAT_CNT_MSB 7
`define LUTR_STAT_LAST_LSB 8
`define LUTR_STAT_LAST_MSB 12

// ==========================================================================
// memory organisations
`define LUTR_MODE_SP16 2'h0
`define LUTR_MODE_DUAL 2'h1
`define LUTR_MODE_SP32 2'h2
`define LUTR_MODE_DP16 2'h3

// ==========================================================================
// reset and preload values
`define LUTR_RST_MODE 2'h0
`define LUTR_RST_FALL 1'b0
`define LUTR_RST_CNT 8'h00
`define LUTR_RST_LAST 5'h00
`define LUTR_INIT_LO 16'h0000
`define LUTR_INIT_HI 16'h0000

`endif

// ---- lutr_lut16.v ----
/*
  One 16x1 lookup-table memory: clocked write, combinational read, preload
  value loaded at configuration and on a reload pulse.
  Assumes write strobes are synchronous to clk; carries no reset on purpose.
*/
`timescale 1ns/100ps
`include "lutr_map.vh"

module lutr_lut16 #(
  parameter [15:0] INIT = `LUTR_INIT_LO
) (
  // clock
  input wire clk,
  // write side
  input wire wr_pulse,
  input wire [3:0] wr_addr,
  input wire wr_data,
  input wire reload,
  // read side
  input wire [3:0] rd_addr,
  output wire rd_data,
  output wire [15:0] bits
);

  // ========================================================================
  // storage
  reg [15:0] mem_r;

  initial begin
    mem_r = INIT;
  end

  // no reset term, contents survive set/reset
  // write pulse stores the captured bit
  always @(posedge clk) begin
    if (reload) begin
      mem_r <= INIT;
    end else if (wr_pulse) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem_r[rd_addr];
  assign bits = mem_r;

endmodule

// ---- lutr_top.v ----
/*
  Lookup-table RAM cell: two 16x1 arrays organised as single-port 16x1,
  two independent 16x1, single-port 32x1 or dual-port 16x1, plus an APB3
  slave for organisation, write-edge polarity, reload and status.
  Assumes user memory ports come from logic on clk (no synchronisers), and
  that rst_b is the global set/reset of the cell's flip-flops.
*/
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "lutr_map.vh"

// Function
// - writes only on a clock edge, reads combinational from the address
// - organisations: 16x1, two 16x1, 32x1; dual-port is 16x1 only
// - 16x1 mode: 16 bits, one 4-bit address for write and read
// - two-array mode: separate address and data, shared enable and clock
// - 32x1 mode: 32 bits, 5-bit address, extra input is fifth bit
// - dual-port: primary address reads and writes, secondary only reads
// - edge captures address, data, enable; a later pulse stores it
// - write edge selectable rising (default) or falling
// - write enable is active high, no inversion option
// - primary output follows contents at the current address
// - overwriting the read location updates the output after the write
// - dual-port allows write and secondary read together, any addresses
// - lower array uses primary address, shown on primary output
// - upper array written at primary address, read at secondary address
// - configuration loads preload contents, zero when none given
// - contents only set at configuration, untouched by set/reset
module lutr_top #(
  parameter [15:0] INIT_LO = `LUTR_INIT_LO,
  parameter [15:0] INIT_HI = `LUTR_INIT_HI
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // memory write side
  input wire write_enable,
  input wire [1:0] write_data_in,
  input wire [3:0] primary_address,
  input wire upper_address_bit,
  input wire [3:0] second_array_address,
  // memory read side
  input wire [3:0] secondary_read_address,
  output wire primary_read_out,
  output wire second_array_read_out,
  output wire secondary_read_out
);

  // ========================================================================
  // declarations
  reg [1:0] mode_r;
  reg wclk_fall_r;
  reg reload_r;
  reg [7:0] wr_cnt_r;
  reg [4:0] last_addr_r;
  reg [31:0] prdata_r;
  reg pready_r;
  reg pslverr_r;
  // rising-edge capture
  reg cap_p_we_r;
  reg [1:0] cap_p_data_r;
  reg [3:0] cap_p_addr_r;
  reg cap_p_upper_r;
  reg [3:0] cap_p_addr_b_r;
  // falling-edge capture
  reg cap_n_we_r;
  reg [1:0] cap_n_data_r;
  reg [3:0] cap_n_addr_r;
  reg cap_n_upper_r;
  reg [3:0] cap_n_addr_b_r;
  // selected capture
  wire cap_we;
  wire [1:0] cap_data;
  wire [3:0] cap_addr;
  wire cap_upper;
  wire [3:0] cap_addr_b;
  // per-array steering
  reg [1:0] arr_we;
  reg [7:0] arr_waddr;
  reg [1:0] arr_wdata;
  reg [7:0] arr_raddr;
  wire [1:0] arr_rdata;
  wire [31:0] arr_bits;
  // bus decode
  wire apb_access;
  wire apb_done;
  reg [31:0] rd_word;
  reg rd_hit;

  // ========================================================================
  // write capture on the rising edge

  // rising edge path, idle when falling is chosen
  // enable taken as is, active high
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_p_we_r <= 1'b0;
      cap_p_data_r <= 2'h0;
      cap_p_addr_r <= 4'h0;
      cap_p_upper_r <= 1'b0;
      cap_p_addr_b_r <= 4'h0;
    end else begin
      cap_p_we_r <= write_enable & ~wclk_fall_r;
      cap_p_data_r <= write_data_in;
      cap_p_addr_r <= primary_address;
      cap_p_upper_r <= upper_address_bit;
      cap_p_addr_b_r <= second_array_address;
    end
  end

  // ========================================================================
  // write capture on the falling edge

  // falling edge path, independent of the bus flops' edge
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_n_we_r <= 1'b0;
      cap_n_data_r <= 2'h0;
      cap_n_addr_r <= 4'h0;
      cap_n_upper_r <= 1'b0;
      cap_n_addr_b_r <= 4'h0;
    end else begin
      cap_n_we_r <= write_enable & wclk_fall_r;
      cap_n_data_r <= write_data_in;
      cap_n_addr_r <= primary_address;
      cap_n_upper_r <= upper_address_bit;
      cap_n_addr_b_r <= second_array_address;
    end
  end

  // captured set chosen by polarity, pulse on next rising edge
  // flipping polarity mid-stream may drop one captured write; keep it static
  assign cap_we = wclk_fall_r ? cap_n_we_r : cap_p_we_r;
  assign cap_data = wclk_fall_r ? cap_n_data_r : cap_p_data_r;
  assign cap_addr = wclk_fall_r ? cap_n_addr_r : cap_p_addr_r;
  assign cap_upper = wclk_fall_r ? cap_n_upper_r : cap_p_upper_r;
  assign cap_addr_b = wclk_fall_r ? cap_n_addr_b_r : cap_p_addr_b_r;

  // ========================================================================
  // organisation steering

  always @* begin
    arr_we = 2'h0;
    arr_waddr = {cap_addr, cap_addr};
    arr_wdata = {cap_data[0], cap_data[0]};
    arr_raddr = {primary_address, primary_address};
    case (mode_r)
      // one address for write and read
      `LUTR_MODE_SP16: begin
        arr_we = {1'b0, cap_we};
      end
      // own address and data, shared enable
      `LUTR_MODE_DUAL: begin
        arr_we = {cap_we, cap_we};
        arr_waddr = {cap_addr_b, cap_addr};
        arr_wdata = cap_data;
        arr_raddr = {second_array_address, primary_address};
      end
      `LUTR_MODE_SP32: begin
        arr_we = {cap_we & cap_upper, cap_we & ~cap_upper};
      end
      // upper array written at primary address
      `LUTR_MODE_DP16: begin
        arr_we = {cap_we, cap_we};
        arr_raddr = {secondary_read_address, primary_address};
      end
      default: begin
        arr_we = 2'h0;
      end
    endcase
  end

  // ========================================================================
  // the two arrays
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_arr
      lutr_lut16 #(
        .INIT(g == 0 ? INIT_LO : INIT_HI)
      ) u_lut (
        .clk(clk),
        .wr_pulse(arr_we[g]),
        .wr_addr(arr_waddr[g*4 +: 4]),
        .wr_data(arr_wdata[g]),
        .reload(reload_r),
        .rd_addr(arr_raddr[g*4 +: 4]),
        .rd_data(arr_rdata[g]),
        .bits(arr_bits[g*16 +: 16])
      );
    end
  endgenerate

  // ========================================================================
  // read outputs

  // combinational read, no flop, so written data shows at once
  // lower array drives the primary output
  // live fifth bit picks the half
  assign primary_read_out = (mode_r == `LUTR_MODE_SP32 && upper_address_bit) ?
                            arr_rdata[1] : arr_rdata[0];
  // ports the mode lacks read 0, so a stale mode never leaks the upper array
  assign second_array_read_out = (mode_r == `LUTR_MODE_DUAL) ? arr_rdata[1] : 1'b0;
  // upper array on the secondary output
  assign secondary_read_out = (mode_r == `LUTR_MODE_DP16) ? arr_rdata[1] : 1'b0;

  // ========================================================================
  // write statistics

  // count of stored writes and the last written location
  // a store lost to a reload is not counted, so the count matches the arrays
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_cnt_r <= `LUTR_RST_CNT;
      last_addr_r <= `LUTR_RST_LAST;
    end else if (cap_we && !reload_r) begin
      wr_cnt_r <= wr_cnt_r + 8'h01;
      last_addr_r <= {cap_upper & (mode_r == `LUTR_MODE_SP32), cap_addr};
    end
  end

  // ========================================================================
  // apb slave

  // one wait state: pready rises at the end of the first access cycle
  assign apb_access = psel & penable;
  assign apb_done = apb_access & pready_r;

  // read mux and address decode
  // unmapped offsets answer with an error and zero data
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `LUTR_OFS_CTRL: begin
        rd_word[`LUTR_CTRL_MODE_MSB:`LUTR_CTRL_MODE_LSB] = mode_r;
        rd_word[`LUTR_CTRL_FALL_BIT] = wclk_fall_r;
      end
      `LUTR_OFS_STATUS: begin
        rd_word[`LUTR_STAT_CNT_MSB:`LUTR_STAT_CNT_LSB] = wr_cnt_r;
        rd_word[`LUTR_STAT_LAST_MSB:`LUTR_STAT_LAST_LSB] = last_addr_r;
      end
      `LUTR_OFS_CONT_LO: begin
        rd_word[15:0] = arr_bits[15:0];
      end
      `LUTR_OFS_CONT_HI: begin
        rd_word[15:0] = arr_bits[31:16];
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // answer phase flops; data is zero outside the answer cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (apb_access && !pready_r) begin
      pready_r <= 1'b1;
      prdata_r <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr_r <= ~rd_hit;
    end else begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  // control register; writes land only at the completing edge
  // reload is a configuration step, set/reset never clears contents
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= `LUTR_RST_MODE;
      wclk_fall_r <= `LUTR_RST_FALL;
      reload_r <= 1'b0;
    end else begin
      reload_r <= 1'b0;
      if (apb_done && pwrite && paddr == `LUTR_OFS_CTRL) begin
        mode_r <= pwdata[`LUTR_CTRL_MODE_MSB:`LUTR_CTRL_MODE_LSB];
        wclk_fall_r <= pwdata[`LUTR_CTRL_FALL_BIT];
        reload_r <= pwdata[`LUTR_CTRL_RELOAD_BIT];
      end
    end
  end

  // bus outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

endmodule

// ---- lutr_top_sva.sv ----
/*
  Port checker for the lookup-table RAM cell.
  Assumes a bind from the bench and a single clock domain.
*/
`timescale 1ns/100ps
module lutr_top_sva (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // apb
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  // memory
  input wire write_enable,
  input wire [3:0] primary_address,
  input wire upper_address_bit,
  input wire [3:0] second_array_address,
  input wire [3:0] secondary_read_address,
  input wire primary_read_out,
  input wire second_array_read_out,
  input wire secondary_read_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ==========
  // sequences
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && !pready;
  endsequence
  // no store and no register write could have landed lately
  sequence quiet_s;
    !$past(write_enable) && !$past(write_enable, 2) && !$past(pready) && !$past(pready, 2);
  endsequence
  // ==========
  // bus answer
  chk_ready_after_access: assert property (setup_s ##1 access_s |=> pready)
    else $error("pready missing after access");
  chk_no_early_ready: assert property (setup_s |=> !pready)
    else $error("pready on first access edge");
  chk_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error answer");
  // ==========
  // read outputs move only on address, store or register change
  chk_primary_read_held: assert property (
    quiet_s ##0 ($stable(primary_address) && $stable(upper_address_bit))
    |-> $stable(primary_read_out)) else $error("primary read moved");
  chk_second_array_held: assert property (
    quiet_s ##0 $stable(second_array_address) |-> $stable(second_array_read_out))
    else $error("second array read moved");
  chk_secondary_read_held: assert property (
    quiet_s ##0 $stable(secondary_read_address) |-> $stable(secondary_read_out))
    else $error("secondary read moved");
endmodule

// ---- lutr_user.sv ----
/*
  User logic model on the far side of the memory ports.
  Assumes it shares clk with the cell and drives just after rising edges.
*/
`timescale 1ns/100ps
module lutr_user (
  // clock
  input wire clk,
  // memory ports
  output reg write_enable = 1'b0,
  output reg [1:0] write_data_in = 2'h0,
  output reg [3:0] primary_address = 4'h0,
  output reg upper_address_bit = 1'b0,
  output reg [3:0] second_array_address = 4'h0,
  output reg [3:0] secondary_read_address = 4'h0
);
  // ==========
  // access tasks
  // held across edge
  task wr(input [3:0] a, input u, input [3:0] b, input [1:0] d);
    begin
      @(posedge clk);
      primary_address <= a;
      upper_address_bit <= u;
      second_array_address <= b;
      write_data_in <= d;
      write_enable <= 1'b1;
      @(posedge clk);
      write_enable <= 1'b0;
      write_data_in <= ~d; // stale data never mirrors the write
    end
  endtask
  // addresses only; data wiggles so a leaky enable shows up
  task rd(input [3:0] a, input u, input [3:0] b, input [3:0] s);
    begin
      @(posedge clk);
      primary_address <= a;
      upper_address_bit <= u;
      second_array_address <= b;
      secondary_read_address <= s;
      write_data_in <= ~write_data_in;
    end
  endtask
endmodule

// ---- lut_distributed_ram_test.sv ----
/*
  Self-checking bench for the lookup-table RAM cell.
  Assumes the user model and the bound port checker.
*/
`timescale 1ns/100ps
module lut_distributed_ram_test;
  localparam [15:0] IL = 16'hA5C3;
  localparam [15:0] IH = 16'h0F96;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire write_enable;
  wire [1:0] write_data_in;
  wire [3:0] primary_address;
  wire upper_address_bit;
  wire [3:0] second_array_address;
  wire [3:0] secondary_read_address;
  wire primary_read_out;
  wire second_array_read_out;
  wire secondary_read_out;
  reg [15:0] lo;
  reg [15:0] hi;
  reg [1:0] md;
  reg [7:0] cnt;
  reg [4:0] last;
  reg [31:0] q;
  reg e;
  reg [4:0] i;
  reg [4:0] j;
  integer bad_count = 0;
  integer total_checks = 0;

  // free-running clock
  always #5 clk = ~clk;

  lutr_top #(.INIT_LO(IL), .INIT_HI(IH)) dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .write_enable, .write_data_in, .primary_address,
    .upper_address_bit, .second_array_address, .secondary_read_address, .primary_read_out,
    .second_array_read_out, .secondary_read_out);
  lutr_user u_user (.clk, .write_enable, .write_data_in, .primary_address, .upper_address_bit,
    .second_array_address, .secondary_read_address);

  // ==========
  // tasks
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (bad_count == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // one apb transfer; waits for pready under a bound
  task apb(input w, input [7:0] a, input [31:0] d, output [31:0] r, output er);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk);
      end
      chk(pready, 1'b1);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rreg(input [7:0] a, input [31:0] x, input xe);
    begin
      apb(1'b0, a, 32'h0, q, e);
      chk(q, x);
      chk(e, xe);
    end
  endtask
  // memory write through the user model, mirrored in lo and hi
  task mw(input [3:0] a, input u, input [3:0] b, input [1:0] d);
    begin
      u_user.wr(a, u, b, d);
      if (md == 2'h2 && u)
        hi[a] = d[0];
      else
        lo[a] = d[0];
      if (md == 2'h1)
        hi[b] = d[1];
      if (md == 2'h3)
        hi[a] = d[0];
      cnt = cnt + 8'h01;
      last = {md == 2'h2 && u, a};
    end
  endtask
  task look(input [3:0] a, input u, input [3:0] b, input [3:0] s);
    begin
      u_user.rd(a, u, b, s);
      @(negedge clk);
      chk(primary_read_out, (md == 2'h2 && u) ? hi[a] : lo[a]);
      chk(second_array_read_out, md == 2'h1 ? hi[b] : 1'b0);
      chk(secondary_read_out, md == 2'h3 ? hi[s] : 1'b0);
    end
  endtask

  // ==========
  // main sequence
  initial begin
    lo = IL;
    hi = IH;
    md = 2'h0;
    cnt = 8'h00;
    last = 5'h00;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rreg(8'h00, 32'h0, 1'b0);
    rreg(8'h08, {16'h0, IL}, 1'b0);
    rreg(8'h0C, {16'h0, IH}, 1'b0);
    rreg(8'h10, 32'h0, 1'b1);
    // odd modes use the falling write edge
    for (i = 0; i < 4; i = i + 1) begin
      md = i[1:0];
      apb(1'b1, 8'h00, {29'h0, md[0], md}, q, e);
      for (j = 0; j < 4; j = j + 1)
        mw(j[3:0] * 4'h5, j[0], 4'hF - j[3:0], ~j[1:0]);
      mw(4'h5, 1'b0, 4'h3, {1'b0, ~lo[4'h5]});
      // address still on the overwritten cell; output must follow the store
      @(negedge clk);
      @(negedge clk);
      chk(primary_read_out, lo[4'h5]);
      chk(secondary_read_out, md == 2'h3 ? hi[secondary_read_address] : 1'b0);
      for (j = 0; j < 16; j = j + 1)
        look(j[3:0], j[1], ~j[3:0], j[3:0] ^ 4'h5);
      rreg(8'h04, {19'h0, last, cnt}, 1'b0);
      rreg(8'h08, {16'h0, lo}, 1'b0);
      rreg(8'h0C, {16'h0, hi}, 1'b0);
    end
    // reset mid-run clears flops but not contents
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    md = 2'h0;
    rreg(8'h00, 32'h0, 1'b0);
    rreg(8'h04, 32'h0, 1'b0);
    rreg(8'h08, {16'h0, lo}, 1'b0);
    look(4'h5, 1'b0, 4'h0, 4'h0);
    apb(1'b1, 8'h00, 32'h100, q, e);
    lo = IL;
    hi = IH;
    rreg(8'h00, 32'h0, 1'b0);
    rreg(8'h08, {16'h0, IL}, 1'b0);
    rreg(8'h0C, {16'h0, IH}, 1'b0);
    look(4'h5, 1'b0, 4'h0, 4'h0);
    apb(1'b1, 8'h04, 32'hFF, q, e);
    rreg(8'h04, 32'h0, 1'b0);
    apb(1'b1, 8'h40, 32'h1, q, e);
    chk(e, 1'b1);
    tally_and_finish;
  end

  // watchdog well past the expected run length
  initial begin
    #100000;
    bad_count = bad_count + 1;
    tally_and_finish;
  end
endmodule

bind lutr_top lutr_top_sva u_sva (.clk, .rst_b, .psel, .penable, .pready, .pslverr, .prdata,
  .write_enable, .primary_address, .upper_address_bit, .second_array_address,
  .secondary_read_address, .primary_read_out, .second_array_read_out, .secondary_read_out);
